// [rtl/awt_pkg.sv]
package awt_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets on the host register port
  localparam logic [7:0] AWAKE_OFF_LOW_ADDR   = 8'h1A;
  localparam logic [7:0] AWAKE_OFF_HIGH_ADDR  = 8'h1B;
  localparam logic [7:0] ASLEEP_OFF_LOW_ADDR  = 8'h1C;
  localparam logic [7:0] ASLEEP_OFF_HIGH_ADDR = 8'h1D;
  localparam logic [7:0] LIMIT_LOW_ADDR       = 8'h1E;
  localparam logic [7:0] LIMIT_HIGH_ADDR      = 8'h1F;

  ////////////////////////////////////////////////////////////////////////////
  // Field layout and reset values
  localparam int         VALUE_W        = 12;
  localparam int         LOW_BYTE_W     = 8;
  localparam int         HIGH_NIBBLE_W  = 4;
  localparam int         FLEX_BIT       = 1;
  localparam int         POWER_W        = 2;
  localparam int         RATE_W         = 4;
  localparam int         DEC_W          = 3;
  localparam logic [7:0] LOW_RESET      = 8'h00;
  localparam logic [3:0] HIGH_RESET     = 4'h0;
  localparam logic [7:0] UNMAPPED_READ  = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Off-time step: 312.5 ns per count
  localparam int OFF_STEP_PS     = 312500;
  localparam int CLK_PERIOD_PS   = 25000;
  localparam int OFF_STEP_CYCLES = (OFF_STEP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed
  {
    logic change_outside;
    logic change_inside;
    logic orientation;
  } detect_events_t;

  typedef struct packed
  {
    logic [POWER_W-1:0] power_select;
    logic [RATE_W-1:0]  rate_select;
    logic [DEC_W-1:0]   decimation;
    logic [VALUE_W-1:0] off_time;
  } mode_setup_t;

  typedef struct packed
  {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef enum logic {MODE_AWAKE, MODE_ASLEEP} op_mode_t;

  // Upper bit of a power selection marks the flexible setting
  function automatic logic flexible_power_setting(input logic [POWER_W-1:0] sel);
    return sel[FLEX_BIT];
  endfunction

endpackage

// [rtl/off_time_timer.sv]
`timescale 1ns/1ps
module off_time_timer #(
  parameter int STEP_CYCLES = awt_pkg::OFF_STEP_CYCLES
)
(
  input  wire logic                         sys_clk_i,
  input  wire logic                         rst_n_i,
  input  wire logic                         flexible_i,
  input  wire logic [awt_pkg::VALUE_W-1:0]  off_time_i,
  input  wire logic                         odr_tick_i,
  input  wire logic                         measure_done_i,
  output logic                              sample_tick_o,
  output logic                              measure_start_o
);

  typedef enum logic {PH_MEASURE, PH_OFF} phase_t;

  phase_t                        phase;
  phase_t                        next_phase;
  logic [13:0]                   prescale;
  logic [13:0]                   next_prescale;
  logic [awt_pkg::VALUE_W-1:0]   steps;
  logic [awt_pkg::VALUE_W-1:0]   next_steps;
  logic                          next_sample_tick;
  logic                          next_measure_start;

  always_comb
  begin
    next_phase         = phase;
    next_prescale      = prescale;
    next_steps         = steps;
    next_sample_tick   = 1'b0;
    next_measure_start = 1'b0;
    if (!flexible_i)
    begin
      // Fixed rate modes take the rate timebase directly
      next_phase         = PH_MEASURE;
      next_sample_tick   = odr_tick_i;
      next_measure_start = odr_tick_i;
    end
    else
    begin
      case (phase)
        PH_MEASURE:
        begin
          if (measure_done_i)
          begin
            // Period is measurement time plus off time
            next_phase    = PH_OFF;
            next_steps    = off_time_i;
            next_prescale = 14'(STEP_CYCLES - 1);
          end
        end
        PH_OFF:
        begin
          if (prescale != 14'h0000)
            next_prescale = prescale - 14'h0001;
          else if (steps != 12'h000)
          begin
            // Value n gives n+1 steps, one step at least
            next_steps    = steps - 12'h001;
            next_prescale = 14'(STEP_CYCLES - 1);
          end
          else
          begin
            next_phase         = PH_MEASURE;
            next_sample_tick   = 1'b1;
            next_measure_start = 1'b1;
          end
        end
        default: next_phase = PH_MEASURE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      phase           <= PH_MEASURE;
      prescale        <= 14'h0000;
      steps           <= 12'h000;
      sample_tick_o   <= 1'b0;
      measure_start_o <= 1'b0;
    end
    else
    begin
      phase           <= next_phase;
      prescale        <= next_prescale;
      steps           <= next_steps;
      sample_tick_o   <= next_sample_tick;
      measure_start_o <= next_measure_start;
    end
  end

endmodule

// [rtl/inactivity_counter.sv]
`timescale 1ns/1ps
module inactivity_counter
(
  input  wire logic                         sys_clk_i,
  input  wire logic                         rst_n_i,
  input  wire logic                         awake_i,
  input  wire logic [awt_pkg::VALUE_W-1:0]  limit_i,
  input  wire logic                         sample_tick_i,
  input  wire logic                         restart_i,
  output logic [awt_pkg::VALUE_W-1:0]       count_o,
  output logic                              expire_o
);

  logic [awt_pkg::VALUE_W-1:0] next_count;
  logic [awt_pkg::VALUE_W:0]   bumped;
  logic                        next_expire;

  always_comb
  begin
    bumped      = {1'b0, count_o} + 13'h0001;
    next_count  = count_o;
    next_expire = 1'b0;
    if (!awake_i || restart_i || limit_i == 12'h000)
      next_count = 12'h000;
    else if (sample_tick_i)
    begin
      // One count per awake sample period
      if (bumped >= {1'b0, limit_i})
      begin
        next_expire = 1'b1;
        next_count  = 12'h000;
      end
      else
        next_count = bumped[awt_pkg::VALUE_W-1:0];
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      count_o  <= 12'h000;
      expire_o <= 1'b0;
    end
    else
    begin
      count_o  <= next_count;
      expire_o <= next_expire;
    end
  end

endmodule

// [rtl/auto_wake_sleep_timing.sv]
`timescale 1ns/1ps
module auto_wake_sleep_timing #(
  parameter int STEP_CYCLES = awt_pkg::OFF_STEP_CYCLES
)
(
  input  wire logic                          sys_clk_i,
  input  wire logic                          rst_n_i,
  input  wire awt_pkg::reg_req_t             reg_req_i,
  input  wire logic [awt_pkg::POWER_W-1:0]   awake_power_select_i,
  input  wire logic [awt_pkg::RATE_W-1:0]    awake_rate_select_i,
  input  wire logic [awt_pkg::DEC_W-1:0]     awake_decimation_i,
  input  wire logic [awt_pkg::POWER_W-1:0]   asleep_power_select_i,
  input  wire logic [awt_pkg::RATE_W-1:0]    asleep_rate_select_i,
  input  wire logic [awt_pkg::DEC_W-1:0]     asleep_decimation_i,
  input  wire logic                          odr_tick_i,
  input  wire logic                          measure_done_i,
  input  wire awt_pkg::detect_events_t       detect_events_i,
  input  wire awt_pkg::detect_events_t       detect_enable_i,
  input  wire logic                          buffer_event_cleared_i,
  input  wire logic                          buffer_event_keeps_awake_i,
  input  wire logic                          buffer_gate_i,
  input  wire logic                          buffer_empty_i,
  output logic [7:0]                         reg_rdata_o,
  output logic                               reg_rvalid_o,
  output logic                               asleep_o,
  output logic                               mode_change_o,
  output awt_pkg::mode_setup_t               active_setup_o,
  output logic                               sample_tick_o,
  output logic                               measure_start_o,
  output logic                               buffer_accept_o,
  output logic [awt_pkg::VALUE_W-1:0]        inactivity_count_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Register bank

  logic [7:0] awake_off_time_low;
  logic [3:0] awake_off_time_high;
  logic [7:0] asleep_off_time_low;
  logic [3:0] asleep_off_time_high;
  logic [7:0] inactivity_limit_low;
  logic [3:0] inactivity_limit_high;
  logic [7:0] next_awake_off_time_low;
  logic [3:0] next_awake_off_time_high;
  logic [7:0] next_asleep_off_time_low;
  logic [3:0] next_asleep_off_time_high;
  logic [7:0] next_inactivity_limit_low;
  logic [3:0] next_inactivity_limit_high;
  logic [7:0] next_reg_rdata;
  logic       next_reg_rvalid;

  always_comb
  begin
    next_awake_off_time_low    = awake_off_time_low;
    next_awake_off_time_high   = awake_off_time_high;
    next_asleep_off_time_low   = asleep_off_time_low;
    next_asleep_off_time_high  = asleep_off_time_high;
    next_inactivity_limit_low  = inactivity_limit_low;
    next_inactivity_limit_high = inactivity_limit_high;
    if (reg_req_i.wr)
    begin
      // Only the low nibble of a high register is kept
      case (reg_req_i.addr)
        awt_pkg::AWAKE_OFF_LOW_ADDR:   next_awake_off_time_low    = reg_req_i.wdata;
        awt_pkg::AWAKE_OFF_HIGH_ADDR:  next_awake_off_time_high   = reg_req_i.wdata[3:0];
        awt_pkg::ASLEEP_OFF_LOW_ADDR:  next_asleep_off_time_low   = reg_req_i.wdata;
        awt_pkg::ASLEEP_OFF_HIGH_ADDR: next_asleep_off_time_high  = reg_req_i.wdata[3:0];
        awt_pkg::LIMIT_LOW_ADDR:       next_inactivity_limit_low  = reg_req_i.wdata;
        awt_pkg::LIMIT_HIGH_ADDR:      next_inactivity_limit_high = reg_req_i.wdata[3:0];
        default:                       next_awake_off_time_low    = awake_off_time_low;
      endcase
    end
    next_reg_rvalid = reg_req_i.rd;
    next_reg_rdata  = reg_rdata_o;
    if (reg_req_i.rd)
    begin
      // Reserved bits read as zero
      case (reg_req_i.addr)
        awt_pkg::AWAKE_OFF_LOW_ADDR:   next_reg_rdata = awake_off_time_low;
        awt_pkg::AWAKE_OFF_HIGH_ADDR:  next_reg_rdata = {4'h0, awake_off_time_high};
        awt_pkg::ASLEEP_OFF_LOW_ADDR:  next_reg_rdata = asleep_off_time_low;
        awt_pkg::ASLEEP_OFF_HIGH_ADDR: next_reg_rdata = {4'h0, asleep_off_time_high};
        awt_pkg::LIMIT_LOW_ADDR:       next_reg_rdata = inactivity_limit_low;
        awt_pkg::LIMIT_HIGH_ADDR:      next_reg_rdata = {4'h0, inactivity_limit_high};
        default:                       next_reg_rdata = awt_pkg::UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      awake_off_time_low    <= awt_pkg::LOW_RESET;
      awake_off_time_high   <= awt_pkg::HIGH_RESET;
      asleep_off_time_low   <= awt_pkg::LOW_RESET;
      asleep_off_time_high  <= awt_pkg::HIGH_RESET;
      inactivity_limit_low  <= awt_pkg::LOW_RESET;
      inactivity_limit_high <= awt_pkg::HIGH_RESET;
      reg_rdata_o           <= 8'h00;
      reg_rvalid_o          <= 1'b0;
    end
    else
    begin
      awake_off_time_low    <= next_awake_off_time_low;
      awake_off_time_high   <= next_awake_off_time_high;
      asleep_off_time_low   <= next_asleep_off_time_low;
      asleep_off_time_high  <= next_asleep_off_time_high;
      inactivity_limit_low  <= next_inactivity_limit_low;
      inactivity_limit_high <= next_inactivity_limit_high;
      reg_rdata_o           <= next_reg_rdata;
      reg_rvalid_o          <= next_reg_rvalid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assembled 12-bit values

  logic [awt_pkg::VALUE_W-1:0] awake_off_time;
  logic [awt_pkg::VALUE_W-1:0] asleep_off_time;
  logic [awt_pkg::VALUE_W-1:0] inactivity_limit_value;
  logic                        auto_enabled;

  // Reserved upper bits never reach the value
  function automatic logic [awt_pkg::VALUE_W-1:0] join_value(
    input logic [awt_pkg::HIGH_NIBBLE_W-1:0] high,
    input logic [awt_pkg::LOW_BYTE_W-1:0]    low
  );
    return {high, low};
  endfunction

  // Off time counts only in the flexible setting
  function automatic logic [awt_pkg::VALUE_W-1:0] gated_off_time(
    input logic [awt_pkg::POWER_W-1:0] power_select,
    input logic [awt_pkg::VALUE_W-1:0] off_time
  );
    return awt_pkg::flexible_power_setting(power_select) ? off_time : 12'h000;
  endfunction

  assign awake_off_time         = join_value(awake_off_time_high, awake_off_time_low);
  assign asleep_off_time        = join_value(asleep_off_time_high, asleep_off_time_low);
  assign inactivity_limit_value = join_value(inactivity_limit_high, inactivity_limit_low);
  assign auto_enabled           = inactivity_limit_value != 12'h000;

  ////////////////////////////////////////////////////////////////////////////
  // Operating mode

  awt_pkg::op_mode_t mode;
  awt_pkg::op_mode_t next_mode;
  logic              wake_event;
  logic              restart;
  logic              expire;
  logic              next_mode_change;

  // Buffer flag clears never appear here, so they cannot wake
  assign wake_event = |(detect_events_i & detect_enable_i);
  assign restart    = wake_event
                    | (buffer_event_cleared_i & buffer_event_keeps_awake_i);

  always_comb
  begin
    next_mode = mode;
    case (mode)
      awt_pkg::MODE_AWAKE:
      begin
        if (auto_enabled && expire && !wake_event)
          next_mode = awt_pkg::MODE_ASLEEP;
      end
      awt_pkg::MODE_ASLEEP:
      begin
        // Disabling the feature also returns to awake
        if (wake_event || !auto_enabled)
          next_mode = awt_pkg::MODE_AWAKE;
      end
      default: next_mode = awt_pkg::MODE_AWAKE;
    endcase
    next_mode_change = next_mode != mode;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mode          <= awt_pkg::MODE_AWAKE;
      asleep_o      <= 1'b0;
      mode_change_o <= 1'b0;
    end
    else
    begin
      mode          <= next_mode;
      asleep_o      <= next_mode == awt_pkg::MODE_ASLEEP;
      mode_change_o <= next_mode_change;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-mode setup

  awt_pkg::mode_setup_t next_active_setup;

  always_comb
  begin
    // Each mode takes its own selection fields
    if (next_mode == awt_pkg::MODE_ASLEEP)
    begin
      next_active_setup.power_select = asleep_power_select_i;
      next_active_setup.rate_select  = asleep_rate_select_i;
      next_active_setup.decimation   = asleep_decimation_i;
      // Off time ignored outside the flexible setting
      next_active_setup.off_time     = gated_off_time(asleep_power_select_i, asleep_off_time);
    end
    else
    begin
      next_active_setup.power_select = awake_power_select_i;
      next_active_setup.rate_select  = awake_rate_select_i;
      next_active_setup.decimation   = awake_decimation_i;
      // Awake off time hidden outside the flexible setting
      next_active_setup.off_time     = gated_off_time(awake_power_select_i, awake_off_time);
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      active_setup_o <= '0;
    else
      active_setup_o <= next_active_setup;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample period and inactivity count

  off_time_timer #(
    .STEP_CYCLES (STEP_CYCLES)
  ) u_off_time_timer (
    .sys_clk_i       (sys_clk_i),
    .rst_n_i         (rst_n_i),
    .flexible_i      (awt_pkg::flexible_power_setting(active_setup_o.power_select)),
    .off_time_i      (active_setup_o.off_time),
    .odr_tick_i      (odr_tick_i),
    .measure_done_i  (measure_done_i),
    .sample_tick_o   (sample_tick_o),
    .measure_start_o (measure_start_o)
  );

  // Counts only awake periods, held clear while asleep
  // Follows the next mode, so a late tick cannot leave a count as sleep starts
  inactivity_counter u_inactivity_counter (
    .sys_clk_i     (sys_clk_i),
    .rst_n_i       (rst_n_i),
    .awake_i       (next_mode == awt_pkg::MODE_AWAKE),
    .limit_i       (inactivity_limit_value),
    .sample_tick_i (sample_tick_o),
    .restart_i     (restart),
    .count_o       (inactivity_count_o),
    .expire_o      (expire)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Buffer gating after a mode change

  logic buffer_blocked;
  logic next_buffer_blocked;

  always_comb
  begin
    // Set wins over the empty release, so no mixed-rate sample slips in
    if (next_mode_change && buffer_gate_i)
      next_buffer_blocked = 1'b1;
    else if (buffer_empty_i || !buffer_gate_i)
      next_buffer_blocked = 1'b0;
    else
      next_buffer_blocked = buffer_blocked;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      buffer_blocked  <= 1'b0;
      buffer_accept_o <= 1'b1;
    end
    else
    begin
      buffer_blocked  <= next_buffer_blocked;
      buffer_accept_o <= !next_buffer_blocked;
    end
  end

endmodule

// [verif/auto_wake_sleep_timing_assertions.sv]
`timescale 1ns/1ps
module auto_wake_sleep_timing_assertions #(
  parameter int STEP_CYCLES = awt_pkg::OFF_STEP_CYCLES
)
(
  input wire logic                    sys_clk_i,
  input wire logic                    rst_n_i,
  input wire awt_pkg::reg_req_t       reg_req_i,
  input wire logic                    odr_tick_i,
  input wire awt_pkg::detect_events_t detect_events_i,
  input wire awt_pkg::detect_events_t detect_enable_i,
  input wire logic                    buffer_gate_i,
  input wire logic [7:0]              reg_rdata_o,
  input wire logic                    reg_rvalid_o,
  input wire logic                    asleep_o,
  input wire logic                    mode_change_o,
  input wire awt_pkg::mode_setup_t    active_setup_o,
  input wire logic                    sample_tick_o,
  input wire logic                    measure_start_o,
  input wire logic                    buffer_accept_o,
  input wire logic [11:0]             inactivity_count_o
);
  logic hit;
  assign hit = |(detect_events_i & detect_enable_i);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////////////////////
  property p_rd_answer; reg_req_i.rd |=> reg_rvalid_o; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_high_nibble;
    reg_req_i.rd && reg_req_i.addr[0] && reg_req_i.addr[7:4] == 4'h1 |=> reg_rdata_o[7:4] == 4'h0;
  endproperty
  a_high_nibble: assert property (p_high_nibble) else $error("upper nibble not zero");
  property p_change; mode_change_o |-> asleep_o != $past(asleep_o); endproperty
  a_change: assert property (p_change) else $error("change pulse without change");
  property p_wake_now; asleep_o && hit |=> !asleep_o; endproperty
  a_wake_now: assert property (p_wake_now) else $error("event did not wake");
  property p_asleep_clear; asleep_o |-> inactivity_count_o == 12'h000; endproperty
  a_asleep_clear: assert property (p_asleep_clear) else $error("count not clear");
  property p_event_restart; !asleep_o && hit |=> inactivity_count_o == 12'h000; endproperty
  a_event_restart: assert property (p_event_restart) else $error("no restart");
  property p_count_step;
    sample_tick_o && !asleep_o && !hit |=>
      inactivity_count_o == $past(inactivity_count_o) + 12'h001 || inactivity_count_o == 12'h000;
  endproperty
  a_count_step: assert property (p_count_step) else $error("bad count step");
  property p_odr_follow;
    odr_tick_i && !active_setup_o.power_select[1] |=> sample_tick_o;
  endproperty
  a_odr_follow: assert property (p_odr_follow) else $error("rate tick lost");
  property p_start_pair; sample_tick_o |-> measure_start_o; endproperty
  a_start_pair: assert property (p_start_pair) else $error("start not paired");
  property p_fixed_off;
    !active_setup_o.power_select[1] |-> active_setup_o.off_time == 12'h000;
  endproperty
  a_fixed_off: assert property (p_fixed_off) else $error("off time used");
  property p_gate; mode_change_o && $past(buffer_gate_i) |-> !buffer_accept_o; endproperty
  a_gate: assert property (p_gate) else $error("buffer not gated");
endmodule

bind auto_wake_sleep_timing auto_wake_sleep_timing_assertions #(.STEP_CYCLES(STEP_CYCLES)) u_chk (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_req_i(reg_req_i), .odr_tick_i(odr_tick_i),
  .detect_events_i(detect_events_i), .detect_enable_i(detect_enable_i),
  .buffer_gate_i(buffer_gate_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
  .asleep_o(asleep_o), .mode_change_o(mode_change_o), .active_setup_o(active_setup_o),
  .sample_tick_o(sample_tick_o), .measure_start_o(measure_start_o),
  .buffer_accept_o(buffer_accept_o), .inactivity_count_o(inactivity_count_o)
);

// [verif/auto_wake_sleep_timing_tb_top.sv]
`timescale 1ns/1ps
module auto_wake_sleep_timing_tb_top;
  // Short step keeps flexible periods to a few cycles
  localparam int STEP = 4;
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_t;
  logic                    sys_clk_i;
  logic                    rst_n_i;
  awt_pkg::reg_req_t       req;
  logic [1:0]              wpow, spow;
  logic                    odr, mdone, bclr, keep, gate, bempty;
  awt_pkg::detect_events_t ev, en;
  logic [7:0]              rdata, v;
  logic                    rvalid, asleep, mchg, stick, mstart, accept;
  awt_pkg::mode_setup_t    setup;
  logic [11:0]             cnt;
  int                      err_total, total_checks, p0, p3;
  row_t rows[8] = '{'{8'h1A, 8'hA5, 8'hA5}, '{8'h1B, 8'hF7, 8'h07}, '{8'h1C, 8'h3C, 8'h3C},
                    '{8'h1D, 8'h9E, 8'h0E}, '{8'h1E, 8'h81, 8'h81}, '{8'h1F, 8'h5B, 8'h0B},
                    '{8'h20, 8'hFF, 8'h00}, '{8'h19, 8'h77, 8'h00}};

  auto_wake_sleep_timing #(.STEP_CYCLES(STEP)) uut (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_req_i(req),
    .awake_power_select_i(wpow), .awake_rate_select_i(4'hA), .awake_decimation_i(3'h5),
    .asleep_power_select_i(spow), .asleep_rate_select_i(4'h3), .asleep_decimation_i(3'h6),
    .odr_tick_i(odr), .measure_done_i(mdone), .detect_events_i(ev), .detect_enable_i(en),
    .buffer_event_cleared_i(bclr), .buffer_event_keeps_awake_i(keep), .buffer_gate_i(gate),
    .buffer_empty_i(bempty), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .asleep_o(asleep),
    .mode_change_o(mchg), .active_setup_o(setup), .sample_tick_o(stick),
    .measure_start_o(mstart), .buffer_accept_o(accept), .inactivity_count_o(cnt)
  );

  initial
  begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge sys_clk_i);
    req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge sys_clk_i);
    req.rd <= 1'b0;
    @(negedge sys_clk_i);
    chk({15'h0000, rvalid}, 16'h0001);
    d = rdata;
  endtask

  // 0 rate tick, 2 buffer flag clear, 3 buffer empty, other all events
  task automatic pulse(input int k);
    @(posedge sys_clk_i);
    case (k)
      0: odr <= 1'b1;
      2: bclr <= 1'b1;
      3: bempty <= 1'b1;
      default: ev <= 3'b111;
    endcase
    @(posedge sys_clk_i);
    {odr, bclr, bempty} <= 3'b000;
    ev <= 3'b000;
    @(posedge sys_clk_i);
    @(negedge sys_clk_i);
  endtask

  // Cycles from end of measurement to the next sample tick
  task automatic period(output int n);
    @(posedge sys_clk_i);
    mdone <= 1'b1;
    @(posedge sys_clk_i);
    mdone <= 1'b0;
    n = 0;
    while (stick !== 1'b1 && n < 100)
    begin
      @(negedge sys_clk_i);
      n++;
    end
    chk({14'h0000, stick, mstart}, 16'h0003);
    if (stick !== 1'b1)
      report_and_stop();
  endtask

  task automatic wait_mode(input logic m);
    int n;
    n = 0;
    while (asleep !== m && n < 20)
    begin
      @(negedge sys_clk_i);
      n++;
    end
    chk({15'h0000, asleep}, {15'h0000, m});
    chk({15'h0000, mchg}, 16'h0001);
    if (asleep !== m)
      report_and_stop();
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    req = '0;
    {wpow, spow} = 4'h0;
    {odr, mdone, bclr, keep, gate, bempty} = 6'h00;
    ev = 3'b000;
    en = 3'b000;
    rst_n_i = 1'b0;
    repeat (5) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    foreach (rows[i])
    begin
      rd(rows[i].a, v);
      chk({8'h00, v}, 16'h0000);
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, v);
      chk({8'h00, v}, {8'h00, rows[i].e});
    end
    // Awake flexible setup, then fixed setting hides the off time
    @(posedge sys_clk_i) wpow <= 2'b10;
    wr(8'h1A, 8'h34);
    wr(8'h1B, 8'hF2);
    repeat (2) @(negedge sys_clk_i);
    chk({4'h0, setup.off_time}, 16'h0234);
    chk({7'h00, setup.power_select, setup.rate_select, setup.decimation}, 16'h0155);
    @(posedge sys_clk_i) wpow <= 2'b01;
    repeat (2) @(negedge sys_clk_i);
    chk({4'h0, setup.off_time}, 16'h0000);
    // Each extra off count lengthens the period by one step
    @(posedge sys_clk_i) wpow <= 2'b10;
    wr(8'h1A, 8'h00);
    wr(8'h1B, 8'h00);
    period(p0);
    period(p0);
    wr(8'h1A, 8'h03);
    period(p3);
    period(p3);
    chk(16'(p3 - p0), 16'(3 * STEP));
    chk({15'h0000, p0 > STEP}, 16'h0001);
    // Inactivity counting in a fixed rate setting
    @(posedge sys_clk_i);
    wpow <= 2'b00;
    spow <= 2'b11;
    gate <= 1'b1;
    en <= 3'b001;
    wr(8'h1E, 8'h03);
    wr(8'h1F, 8'hF0);
    pulse(4);
    chk({4'h0, cnt}, 16'h0000);
    pulse(0);
    pulse(0);
    chk({4'h0, cnt}, 16'h0002);
    @(posedge sys_clk_i) en <= 3'b000;
    pulse(4);
    chk({4'h0, cnt}, 16'h0002);
    pulse(2);
    chk({4'h0, cnt}, 16'h0002);
    @(posedge sys_clk_i) keep <= 1'b1;
    pulse(2);
    chk({4'h0, cnt}, 16'h0000);
    pulse(0);
    pulse(0);
    chk({15'h0000, asleep}, 16'h0000);
    pulse(0);
    wait_mode(1'b1);
    chk({15'h0000, accept}, 16'h0000);
    chk({4'h0, setup.off_time}, 16'h0E3C);
    chk({7'h00, setup.power_select, setup.rate_select, setup.decimation}, 16'h019E);
    pulse(2);
    chk({15'h0000, asleep}, 16'h0001);
    pulse(3);
    chk({15'h0000, accept}, 16'h0001);
    @(posedge sys_clk_i) en <= 3'b100;
    pulse(4);
    chk({15'h0000, asleep}, 16'h0000);
    chk({15'h0000, accept}, 16'h0000);
    // Zero limit stops all counting
    wr(8'h1E, 8'h00);
    wr(8'h1F, 8'h00);
    repeat (3) pulse(0);
    chk({3'h0, asleep, cnt}, 16'h0000);
    // Reset in mid-run clears the bank and reopens the buffer
    @(posedge sys_clk_i) rst_n_i <= 1'b0;
    @(posedge sys_clk_i) rst_n_i <= 1'b1;
    rd(8'h1C, v);
    chk({7'h00, v, accept}, 16'h0001);
    report_and_stop();
  end
endmodule
